// >>> logic/gvc_conversion.sv
// Top of the GOOSE value conversion logic, all outputs registered
`timescale 1ns/1ps
// Summary of operation
// R1: Amplitude forwarded, zero when invalid
// R2: Phase forwarded, zero when invalid
// R3: Quality good when none or only test
// R4: Quality bad when any non-test bit
// R5: Link alive one, zero on timeout
// R6: Health gives exactly one of ok/warn/alarm
// R7: Missing or invalid health means alarm
// R8: Float rounds to byte, saturates
// R9: Invalid direction input clears both outputs
// R10: Direction outputs from enumeration only
// R11: Enum 1 lower, 2 raise, else none
// R12: Word 1 lower, 2 raise, else none
// R13: Encoder none 0, lower 1, raise 2
// R14: Open/closed flags, zero when invalid
// R15: Position healthy unless faulty/intermediate or invalid
// R16: Valid needs link alive and good quality
// R17: Enum and word zero when invalid
// R18: Health 1 ok, 2 warning, else alarm
// R19: Both raise and lower encode zero
module gvc_conversion
  import gvc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic link_up,
  input wire logic [GVC_QUAL_W-1:0] rx_quality,
  input wire logic [1:0] dp_source,
  input wire logic [GVC_FLOAT_W-1:0] amplitude_source,
  input wire logic [GVC_FLOAT_W-1:0] phase_source,
  input wire logic [GVC_ENUM_W-1:0] enum_source,
  input wire logic [GVC_WORD_W-1:0] word_source,
  input wire logic [GVC_QUAL_W-1:0] eval_quality,
  input wire logic [GVC_ENUM_W-1:0] health_in,
  input wire logic health_valid,
  input wire logic [GVC_ENUM_W-1:0] dir_in,
  input wire logic dir_valid,
  input wire logic [GVC_FLOAT_W-1:0] float_in,
  input wire logic [GVC_ENUM_W-1:0] cmd_enum_in,
  input wire logic [GVC_WORD_W-1:0] cmd_word_in,
  input wire logic raise_in,
  input wire logic lower_in,
  output logic valid_ff,
  output logic position_open_flag_ff,
  output logic position_closed_flag_ff,
  output logic position_ok_ff,
  output logic [GVC_FLOAT_W-1:0] amplitude_out_ff,
  output logic [GVC_FLOAT_W-1:0] phase_out_ff,
  output logic [GVC_ENUM_W-1:0] enum_out_ff,
  output logic [GVC_WORD_W-1:0] word_out_ff,
  output logic quality_good_ff,
  output logic quality_bad_ff,
  output logic peer_link_alive_ff,
  output logic health_ok_ff,
  output logic health_warning_ff,
  output logic health_alarm_ff,
  output logic [GVC_BYTE_W-1:0] byte_out_ff,
  output logic direction_forward_ff,
  output logic direction_backward_ff,
  output logic enum_raise_ff,
  output logic enum_lower_ff,
  output logic word_raise_ff,
  output logic word_lower_ff,
  output logic [GVC_WORD_W-1:0] cmd_word_out_ff
);
  // Decoded command pair, raise in bit 1
  function automatic logic [1:0] gvc_cmd_decode(input logic [GVC_WORD_W-1:0] code);
    if (code == GVC_CMD_LOWER) begin
      // Lower only
      return 2'h1;
    end else if (code == GVC_CMD_RAISE) begin
      // Raise only
      return 2'h2;
    end else begin
      // Zero and every unlisted code give no command
      return 2'h0;
    end
  endfunction

  // Quality bits other than test
  function automatic logic gvc_qual_bad(input logic [GVC_QUAL_W-1:0] q);
    return |(q & ~GVC_TEST_MASK);
  endfunction

  // Combinational terms feeding the output blocks
  logic nxt_valid; // Combined receive validity
  logic [1:0] enum_cmd; // Enumerated command decode
  logic [1:0] word_cmd; // Integer command decode
  logic [GVC_ENUM_W-1:0] health_eff; // Health after invalid substitution

  // Validity gate and decodes, all from the current inputs
  assign nxt_valid = link_up && !gvc_qual_bad(rx_quality); // [R16]
  assign enum_cmd = gvc_cmd_decode({{(GVC_WORD_W-GVC_ENUM_W){1'b0}}, cmd_enum_in}); // [R11]
  assign word_cmd = gvc_cmd_decode(cmd_word_in); // [R12]
  assign health_eff = health_valid ? health_in : GVC_ENUM_ZERO; // [R7]

  // Receiver validity
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      valid_ff <= 1'b0;
    end else begin
      // Valid one cycle after its inputs
      valid_ff <= nxt_valid; // [R16]
    end
  end

  // Double position receiver
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      position_open_flag_ff <= 1'b0;
      position_closed_flag_ff <= 1'b0;
      position_ok_ff <= 1'b0;
    end else begin
      // Flags follow the received position code
      position_open_flag_ff <= nxt_valid && (dp_source == GVC_DP_OPEN); // [R14]
      position_closed_flag_ff <= nxt_valid && (dp_source == GVC_DP_CLOSED); // [R14]
      // Healthy only for a settled end position
      position_ok_ff <= nxt_valid && (dp_source != GVC_DP_INTER)
                        && (dp_source != GVC_DP_BAD); // [R15]
    end
  end

  // Value receivers, zero substitute when invalid
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      amplitude_out_ff <= GVC_FLOAT_ZERO;
      phase_out_ff <= GVC_FLOAT_ZERO;
      enum_out_ff <= GVC_ENUM_ZERO;
      word_out_ff <= GVC_WORD_ZERO;
    end else begin
      amplitude_out_ff <= nxt_valid ? amplitude_source : GVC_FLOAT_ZERO; // [R1]
      phase_out_ff <= nxt_valid ? phase_source : GVC_FLOAT_ZERO; // [R2]
      enum_out_ff <= nxt_valid ? enum_source : GVC_ENUM_ZERO; // [R17]
      word_out_ff <= nxt_valid ? word_source : GVC_WORD_ZERO; // [R17]
    end
  end

  // Quality evaluators
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      quality_good_ff <= 1'b0;
      quality_bad_ff <= 1'b0;
      peer_link_alive_ff <= 1'b0;
    end else begin
      // Test bit alone still counts as good quality
      quality_good_ff <= !gvc_qual_bad(eval_quality); // [R3]
      quality_bad_ff <= gvc_qual_bad(eval_quality); // [R4]
      peer_link_alive_ff <= !eval_quality[GVC_QBIT_TIMEOUT]; // [R5]
    end
  end

  // Health decoder, one hot
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      health_ok_ff <= 1'b0;
      health_warning_ff <= 1'b0;
      health_alarm_ff <= 1'b0;
    end else begin
      health_ok_ff <= (health_eff == GVC_HEALTH_OK); // [R6] [R18]
      health_warning_ff <= (health_eff == GVC_HEALTH_WARN); // [R6] [R18]
      // Alarm covers code 3 and every unknown code
      health_alarm_ff <= (health_eff != GVC_HEALTH_OK)
                         && (health_eff != GVC_HEALTH_WARN); // [R6] [R7] [R18]
    end
  end

  // Direction decoder
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      direction_forward_ff <= 1'b0;
      direction_backward_ff <= 1'b0;
    end else begin
      // Unknown codes and invalid input leave both low
      direction_forward_ff <= dir_valid && (dir_in == GVC_DIR_FORWARD); // [R9] [R10]
      direction_backward_ff <= dir_valid && (dir_in == GVC_DIR_BACKWARD); // [R9] [R10]
    end
  end

  // Command decoders
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      enum_raise_ff <= 1'b0;
      enum_lower_ff <= 1'b0;
      word_raise_ff <= 1'b0;
      word_lower_ff <= 1'b0;
    end else begin
      // Both decoders share one mapping function
      enum_raise_ff <= enum_cmd[1]; // [R11]
      enum_lower_ff <= enum_cmd[0]; // [R11]
      word_raise_ff <= word_cmd[1]; // [R12]
      word_lower_ff <= word_cmd[0]; // [R12]
    end
  end

  // Command encoder
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Cleared while reset is held
      cmd_word_out_ff <= GVC_CMD_NONE;
    end else if (raise_in && !lower_in) begin
      // Raise alone
      cmd_word_out_ff <= GVC_CMD_RAISE; // [R13]
    end else if (lower_in && !raise_in) begin
      // Lower alone
      cmd_word_out_ff <= GVC_CMD_LOWER; // [R13]
    end else begin
      // Neither or both give zero
      cmd_word_out_ff <= GVC_CMD_NONE; // [R13] [R19]
    end
  end

  // Float converter
  // Registered inside, so its latency matches the other outputs [R8]
  gvc_float_to_byte u_f2b (
    .clk_sys(clk_sys),
    .reset(reset),
    .float_in(float_in),
    .byte_ff(byte_out_ff)
  );
endmodule

// >>> logic/gvc_pkg.sv
// Package of constants and types for the GOOSE value conversion logic
package gvc_pkg;
  // Widths of carried values
  localparam int GVC_FLOAT_W = 32;
  localparam int GVC_WORD_W = 32;
  localparam int GVC_ENUM_W = 8;
  localparam int GVC_BYTE_W = 8;
  localparam int GVC_QUAL_W = 13;
  // Quality field positions
  localparam int GVC_QBIT_TEST = 11;
  localparam int GVC_QBIT_TIMEOUT = 2;
  localparam logic [GVC_QUAL_W-1:0] GVC_TEST_MASK = 13'h0800;
  // Reset and invalid substitute values
  localparam logic [GVC_FLOAT_W-1:0] GVC_FLOAT_ZERO = 32'h00000000;
  localparam logic [GVC_WORD_W-1:0] GVC_WORD_ZERO = 32'h00000000;
  localparam logic [GVC_ENUM_W-1:0] GVC_ENUM_ZERO = 8'h00;
  // Health enumeration codes
  localparam logic [GVC_ENUM_W-1:0] GVC_HEALTH_OK = 8'h01;
  localparam logic [GVC_ENUM_W-1:0] GVC_HEALTH_WARN = 8'h02;
  localparam logic [GVC_ENUM_W-1:0] GVC_HEALTH_ALARM = 8'h03;
  // Fault direction codes
  localparam logic [GVC_ENUM_W-1:0] GVC_DIR_FORWARD = 8'h01;
  localparam logic [GVC_ENUM_W-1:0] GVC_DIR_BACKWARD = 8'h02;
  // Command codes
  localparam logic [GVC_WORD_W-1:0] GVC_CMD_NONE = 32'h00000000;
  localparam logic [GVC_WORD_W-1:0] GVC_CMD_LOWER = 32'h00000001;
  localparam logic [GVC_WORD_W-1:0] GVC_CMD_RAISE = 32'h00000002;
  // Double position codes
  localparam logic [1:0] GVC_DP_INTER = 2'h0;
  localparam logic [1:0] GVC_DP_OPEN = 2'h1;
  localparam logic [1:0] GVC_DP_CLOSED = 2'h2;
  localparam logic [1:0] GVC_DP_BAD = 2'h3;
  // Float conversion constants
  localparam int GVC_EXP_BIAS = 127;
  localparam logic [GVC_BYTE_W-1:0] GVC_BYTE_MAX = 8'h7F;
  localparam logic [GVC_BYTE_W-1:0] GVC_BYTE_MIN = 8'h80;
endpackage

// >>> logic/gvc_float_to_byte.sv
// Float to signed byte converter with rounding and saturation
`timescale 1ns/1ps
module gvc_float_to_byte
  import gvc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [GVC_FLOAT_W-1:0] float_in,
  output logic [GVC_BYTE_W-1:0] byte_ff
);
  // Float fields
  logic sign;
  logic [7:0] expo;
  logic [23:0] mant;
  logic [GVC_BYTE_W-1:0] nxt_byte;
  assign sign = float_in[31];
  assign expo = float_in[30:23];
  assign mant = {1'b1, float_in[22:0]};

  // Round half away from zero, then clamp
  always_comb begin
    logic [8:0] amplitude_out;
    logic [31:0] shifted;
    int sh;
    amplitude_out = 9'h000;
    shifted = 32'h00000000;
    sh = 0;
    if (expo < 8'h7E) begin
      // Below one half rounds to zero
      amplitude_out = 9'h000;
    end else if (expo > 8'h86) begin
      // Far out of range
      amplitude_out = 9'h1FF;
    end else begin
      // Keep one fraction bit for rounding
      sh = 23 - (int'(expo) - GVC_EXP_BIAS) - 1;
      shifted = {8'h00, mant} >> sh;
      amplitude_out = 9'((shifted + 32'h1) >> 1);
    end
    if (sign) begin
      nxt_byte = (amplitude_out >= 9'h080) ? GVC_BYTE_MIN : GVC_BYTE_W'(-amplitude_out); // [R8]
    end else begin
      nxt_byte = (amplitude_out >= 9'h07F) ? GVC_BYTE_MAX : amplitude_out[7:0]; // [R8]
    end
  end

  // Output register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      byte_ff <= 8'h00;
    end else begin
      byte_ff <= nxt_byte;
    end
  end
endmodule

// >>> verif/gvc_conversion_properties.sv
// Port checker for the GOOSE value conversion top
`timescale 1ns/1ps
module gvc_conversion_properties
  import gvc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic link_up,
  input wire logic [GVC_QUAL_W-1:0] rx_quality,
  input wire logic [GVC_QUAL_W-1:0] eval_quality,
  input wire logic health_valid,
  input wire logic dir_valid,
  input wire logic raise_in,
  input wire logic lower_in,
  input wire logic [GVC_FLOAT_W-1:0] amplitude_out_ff,
  input wire logic [GVC_FLOAT_W-1:0] phase_out_ff,
  input wire logic quality_bad_ff,
  input wire logic peer_link_alive_ff,
  input wire logic health_ok_ff,
  input wire logic health_warning_ff,
  input wire logic health_alarm_ff,
  input wire logic direction_forward_ff,
  input wire logic direction_backward_ff,
  input wire logic [GVC_WORD_W-1:0] cmd_word_out_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Lost link or a bad received quality bit zeroes carried values
  property p_amp; !$past(link_up) |-> amplitude_out_ff == GVC_FLOAT_ZERO; endproperty
  a_amp: assert property (p_amp) else $error("amplitude not zeroed");
  property p_ph; $past(rx_quality[0]) |-> phase_out_ff == GVC_FLOAT_ZERO; endproperty
  a_ph: assert property (p_ph) else $error("phase not zeroed");
  // Evaluators follow the quality word of the prior edge
  property p_bad; !$past(reset) |-> quality_bad_ff == |($past(eval_quality) & ~GVC_TEST_MASK);
  endproperty
  a_bad: assert property (p_bad) else $error("quality bad wrong");
  property p_link; !$past(reset) |-> peer_link_alive_ff != $past(eval_quality[GVC_QBIT_TIMEOUT]);
  endproperty
  a_link: assert property (p_link) else $error("link alive wrong");
  // Health and direction decoding, command encoding
  property p_one; $onehot0({health_ok_ff, health_warning_ff, health_alarm_ff}); endproperty
  a_one: assert property (p_one) else $error("two health outputs");
  property p_alarm; $past(!health_valid && !reset) |-> health_alarm_ff && !health_ok_ff;
  endproperty
  a_alarm: assert property (p_alarm) else $error("missing health not alarm");
  property p_dir; $past(!dir_valid) |-> !(direction_forward_ff || direction_backward_ff);
  endproperty
  a_dir: assert property (p_dir) else $error("invalid direction shown");
  property p_enc; $past(raise_in && lower_in) |-> cmd_word_out_ff == GVC_CMD_NONE; endproperty
  a_enc: assert property (p_enc) else $error("raise with lower not zero");
endmodule

// >>> verif/gvc_goose_peer.sv
// Behavioural model of the GOOSE receive path feeding the conversion logic
`timescale 1ns/1ps
module gvc_goose_peer
  import gvc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic step,
  input wire logic spoil,
  output logic link_up,
  output logic [GVC_QUAL_W-1:0] rx_quality,
  output logic [1:0] dp_source,
  output logic [GVC_FLOAT_W-1:0] amplitude_source,
  output logic [GVC_FLOAT_W-1:0] phase_source,
  output logic [GVC_ENUM_W-1:0] enum_source,
  output logic [GVC_WORD_W-1:0] word_source
);
  // New frame on each step; spoil may drop the link or raise one quality bit
  always @(posedge clk_sys) begin
    if (reset) begin
      {link_up, rx_quality, dp_source} <= '0;
    end else if (step) begin
      link_up <= !spoil || 1'($urandom);
      rx_quality <= spoil ? 13'(1 << $urandom_range(12))
                          : ($urandom_range(1) ? GVC_TEST_MASK : '0);
      {dp_source, enum_source} <= 10'($urandom);
      {amplitude_source, phase_source, word_source} <= {$urandom, $urandom, $urandom};
    end
  end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the GOOSE value conversion top
`timescale 1ns/1ps
module tb
  import gvc_pkg::*;
();
  logic clk_sys = 1'b0, reset = 1'b1, step = 1'b0, spoil = 1'b0, link_up;
  logic health_valid = 1'b0, dir_valid = 1'b0, raise_in = 1'b0, lower_in = 1'b0;
  logic [GVC_QUAL_W-1:0] eval_quality = 13'h0000, rx_quality;
  logic [GVC_ENUM_W-1:0] health_in = 8'h00, dir_in = 8'h00, cmd_enum_in = 8'h00, enum_source;
  logic [GVC_FLOAT_W-1:0] float_in = 32'h00000000, amplitude_source, phase_source;
  logic [GVC_WORD_W-1:0] cmd_word_in = 32'h00000000, word_source, word_out_ff, cmd_word_out_ff;
  logic [1:0] dp_source;
  logic valid_ff, position_open_flag_ff, position_closed_flag_ff, position_ok_ff;
  logic quality_good_ff, quality_bad_ff, peer_link_alive_ff, direction_forward_ff;
  logic health_ok_ff, health_warning_ff, health_alarm_ff, direction_backward_ff;
  logic enum_raise_ff, enum_lower_ff, word_raise_ff, word_lower_ff;
  logic [GVC_FLOAT_W-1:0] amplitude_out_ff, phase_out_ff;
  logic [GVC_ENUM_W-1:0] enum_out_ff;
  logic [GVC_BYTE_W-1:0] byte_out_ff;
  int errors = 0, total_checks = 0;
  // Rounding and saturation edges of the float converter
  logic [31:0] corner [8] = '{32'h42FF0000, 32'hC3008000, 32'h3F000000, 32'hBF000000,
    32'h42FD0000, 32'hC3010000, 32'h7F800000, 32'h3EFAE148};
  gvc_conversion gvc_conversion_inst (.*);
  gvc_goose_peer gvc_goose_peer_inst (.*);
  always #4 clk_sys = ~clk_sys;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Nearest byte, half away from zero, clamped by sign
  function automatic logic [7:0] f2b(input logic [31:0] f);
    int e, r;
    e = int'(f[30:23]);
    r = (e >= 134) ? 255 : 0;
    if (e >= 126 && e < 134) r = (int'({1'b1, f[22:0]}) + (1 << (149 - e))) >> (150 - e);
    if (f[31]) return (r > 128) ? 8'h80 : 8'(-r);
    return (r > 127) ? 8'h7F : 8'(r);
  endfunction
  task automatic check_all();
    logic g, b;
    logic [7:0] h;
    logic [2:0] p, k;
    logic [3:0] c;
    logic [1:0] d;
    g = link_up && !(|(rx_quality & ~GVC_TEST_MASK));
    b = |(eval_quality & ~GVC_TEST_MASK);
    h = health_valid ? health_in : 8'h00;
    p = {g && dp_source == GVC_DP_OPEN, g && dp_source == GVC_DP_CLOSED, g && ^dp_source};
    k = {h == 8'h01, h == 8'h02, h != 8'h01 && h != 8'h02};
    c = {cmd_enum_in == 8'h02, cmd_enum_in == 8'h01, cmd_word_in == 32'h00000002,
      cmd_word_in == 32'h00000001};
    d = {dir_valid && dir_in == 8'h01, dir_valid && dir_in == 8'h02};
    cmp(valid_ff, g);
    cmp({position_open_flag_ff, position_closed_flag_ff}, p[2:1]);
    cmp(position_ok_ff, p[0]);
    cmp(amplitude_out_ff, g ? amplitude_source : 32'h00000000);
    cmp(phase_out_ff, g ? phase_source : 32'h00000000);
    cmp(enum_out_ff, g ? enum_source : 8'h00);
    cmp(word_out_ff, g ? word_source : 32'h00000000);
    cmp(quality_good_ff, !b);
    cmp(quality_bad_ff, b);
    cmp(peer_link_alive_ff, !eval_quality[2]);
    cmp({health_ok_ff, health_warning_ff, health_alarm_ff}, k);
    cmp(byte_out_ff, f2b(float_in));
    cmp({direction_forward_ff, direction_backward_ff}, d);
    cmp({enum_raise_ff, enum_lower_ff}, c[3:2]);
    cmp({word_raise_ff, word_lower_ff}, c[1:0]);
    cmp(cmd_word_out_ff, (raise_in ^ lower_in) ? (raise_in ? 2 : 1) : 0);
  endtask
  // One frame from the peer plus fresh local inputs, checked after registering
  task automatic apply(input logic [31:0] f, input logic bad);
    @(posedge clk_sys);
    step <= 1'b1;
    spoil <= bad;
    float_in <= f;
    eval_quality <= $urandom_range(1) ? 13'(1 << $urandom_range(12)) : 13'h0000;
    {health_valid, dir_valid} <= {$urandom_range(3) != 0, $urandom_range(3) != 0};
    {health_in, dir_in, cmd_enum_in} <= {8'($urandom_range(4)), 8'($urandom_range(3)),
      8'($urandom_range(3))};
    cmd_word_in <= $urandom_range(1) ? 32'($urandom_range(3)) : $urandom;
    {raise_in, lower_in} <= 2'($urandom);
    @(posedge clk_sys);
    step <= 1'b0;
    @(posedge clk_sys);
    #1 check_all();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h476fcce8));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (corner[i]) apply(corner[i], i[0]);
    $display("test float corners done");
    repeat (400) apply({1'($urandom), 8'(120 + $urandom_range(16)), 23'($urandom)},
      $urandom_range(3) == 0);
    $display("test random traffic done");
    finish_test();
  end
  // About five times the expected run length
  initial begin
    #50000;
    errors++;
    finish_test();
  end
endmodule
bind gvc_conversion gvc_conversion_properties gvc_conversion_properties_inst (.*);
